// ---- src/pios_top.sv ----
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pios_top #(
	parameter int N = 8,
	parameter logic [2*N-1:0] POR_CFG = '0 // Per-pin power-on request, 2 bits each
) (
	input wire logic mclk_i, // System clock, 100 MHz
	input wire logic sys_rst_i, // Async reset, high
	input wire logic ce_i, // Clock enable, freezes state when low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [31:0] paddr_i, // APB address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic [N-1:0] pin_in_i, // Pin levels from pads
	output logic [N-1:0] pin_out_o, // Pin drive values
	output logic [N-1:0] pin_oe_o, // Pin output enables, high drives
	output logic [N-1:0] fab_in_o, // Synchronised inputs to fabric
	input wire logic [N-1:0] fab_out_i, // Output data from fabric
	input wire logic [N-1:0] fab_oe_i, // Output enables from fabric
	input wire logic in_clk_i, // External input clock terminal
	input wire logic in_en_i, // External input enable terminal
	input wire logic in_rst_i, // External input reset terminal
	input wire logic out_clk_i, // External output clock terminal
	input wire logic out_en_i, // External output enable terminal
	input wire logic out_rst_i, // External output reset terminal
	output logic por_pull_up_o, // Port held pulled up out of reset
	output logic por_pull_dn_o, // Port held pulled down out of reset
	output logic por_active_o // Power-on state still governs the pin pulls
);
	import pios_pkg::*;
	// Data paths, all on mclk_i:
	// Pad in -> two pad flops -> input stages -> fabric flop
	// Fabric out -> output stage -> pad flop
	// Fabric OE -> OE stage -> pad flop
	// Foreign clocks are sampled levels, not real clock nets
	// Their edges are found at mclk_i rate, so each must stay
	// below half of mclk_i or edges are lost
	// ce_i low freezes every flop here and in both strobe generators

	pios_apb_req_t req;
	pios_sel_t inclk_r, inen_r, inrst_r, outclk_r, outen_r, outrst_r;
	logic [6:0] ctrl_r;
	logic [N-1:0] meta_r, pin_s_r, stage1_r, stage2_r, out_r, oe_r;
	logic in_tick, in_clr, out_tick, out_clr;
	logic setup, wr_en;
	logic [31:0] rd_nxt;
	logic err_nxt;
	logic [1:0] por_state;

	assign req = '{paddr: paddr_i, psel: psel_i, penable: penable_i, pwrite: pwrite_i,
		pwdata: pwdata_i};
	// Setup cycle decided here; pready comes one cycle later, in the first access cycle, so no access waits
	assign setup = req.psel && !req.penable && !pready_o;
	assign wr_en = req.psel && req.penable && pready_o && req.pwrite && !pslverr_o;

	// Resolve the port's common power-on state from each pin's request
	// Higher pin wins if requests differ; a consistent port
	// never has differing requests, so the order is moot
	function automatic logic [1:0] por_resolve(input logic [2*N-1:0] cfg);
		logic [1:0] res;
		res = PIOS_POR_HIZ;
		for (int i = 0; i < N; i++) begin
			if (cfg[2*i +: 2] != PIOS_POR_DC) begin
				res = cfg[2*i +: 2];
			end
		end
		return res;
	endfunction : por_resolve

	assign por_state = por_resolve(POR_CFG);

	// Pads are asynchronous: two flops before anything reads them
	// Cleared at reset; a pad already high shows one rise afterwards
	// Harmless: every selection returns to its default with reset
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_r <= '0;
			pin_s_r <= '0;
		end else if (ce_i) begin
			meta_r <= pin_in_i;
			pin_s_r <= meta_r;
		end
	end

	// Both generators watch the synchronised pads, never the raw ones,
	// so a pin used as clock or enable sees the same delay as data
	// Pin index is three bits, so N above eight is not reachable
	// Input side strobe generator
	pios_gate #(.N(N)) u_in_gate (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.clk_sel_i(inclk_r),
		.en_sel_i(inen_r),
		.rst_sel_i(inrst_r),
		.ext_clk_i(in_clk_i),
		.ext_en_i(in_en_i),
		.ext_rst_i(in_rst_i),
		.pins_i(pin_s_r),
		.tick_o(in_tick),
		.clr_o(in_clr)
	);

	// Output side strobe generator, one reset selection shared by data and OE
	pios_gate #(.N(N)) u_out_gate (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.clk_sel_i(outclk_r),
		.en_sel_i(outen_r),
		.rst_sel_i(outrst_r),
		.ext_clk_i(out_clk_i),
		.ext_en_i(out_en_i),
		.ext_rst_i(out_rst_i),
		.pins_i(pin_s_r),
		.tick_o(out_tick),
		.clr_o(out_clr)
	);

	// Latency from pad to fabric in default mode: five edges
	// Two pad flops, two stages, one fabric flop
	// Trade-off: the pad flops stay even in transparent mode,
	// so no path from a pad reaches logic unregistered
	// Input synchroniser chain on the selected input clock
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else if (ce_i) begin
			if (in_clr) begin
				// Clear beats any pending update, held while reset stands
				stage1_r <= '0;
				stage2_r <= '0;
			end else if (in_tick) begin
				stage1_r <= pin_s_r;
				stage2_r <= stage1_r;
			end
		end
	end

	// Mode 3 is unused and falls back to double
	// Mode changes take effect at the next edge, with no filtering
	// Fabric view of the pins, per selected sync mode
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fab_in_o <= '0;
		end else if (ce_i) begin
			case (ctrl_r[PIOS_INMODE_LSB +: 2])
				PIOS_IN_SINGLE: fab_in_o <= stage1_r;
				PIOS_IN_TRANSP: fab_in_o <= pin_s_r;
				default: fab_in_o <= stage2_r;
			endcase
		end
	end

	// Data and OE share one strobe and one reset selection,
	// but each clear is gated by its own control bit
	// Reset beats update, as on the input side
	// Output data and OE synchronisers on the selected output clock
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_r <= '0;
			oe_r <= '0;
		end else if (ce_i) begin
			if (out_clr && ctrl_r[PIOS_ORST_BIT]) begin
				out_r <= '0;
			end else if (out_tick) begin
				out_r <= fab_out_i;
			end
			if (out_clr && ctrl_r[PIOS_OERST_BIT]) begin
				oe_r <= '0;
			end else if (out_tick) begin
				oe_r <= fab_oe_i;
			end
		end
	end

	// Pad drivers; transparent paths still pass one flop to keep outputs registered
	// Cost: one extra cycle of latency in transparent modes
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_out_o <= '0;
			pin_oe_o <= '0;
		end else if (ce_i) begin
			pin_out_o <= ctrl_r[PIOS_OSYNC_BIT] ? out_r : fab_out_i;
			pin_oe_o <= ctrl_r[PIOS_OESYNC_BIT] ? oe_r : fab_oe_i;
		end
	end

	// Pulls are outputs of this block only; the pad cell applies them
	// Boot strobe is one-shot: only a full reset re-arms it,
	// but pin_out_o and pin_oe_o are not gated by it, so pulls and the operational drive can overlap
	// Power-on pull state holds until software applies the boot drive
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			por_active_o <= 1'b1;
			por_pull_up_o <= 1'b0;
			por_pull_dn_o <= 1'b0;
		end else if (ce_i) begin
			if (wr_en && req.paddr[7:0] == PIOS_CTRL_OFF && req.pwdata[PIOS_BOOT_BIT]) begin
				por_active_o <= 1'b0;
			end
			por_pull_up_o <= por_active_o && (por_state == PIOS_POR_UP);
			por_pull_dn_o <= por_active_o && (por_state == PIOS_POR_DN);
		end
	end

	// Register map, one word each, unused bits read zero
	// 0x00 control: [1:0] input mode, [2] output sync, [3] OE sync,
	// [4] output reset use, [5] OE reset use, [6] boot strobe
	// 0x04 to 0x18 source selections, same layout for all six:
	// [1:0] source, [2] invert, [5:3] pin index, [6] level mode
	// Level mode only matters in the two enable selections
	// 0x1c status, read only: pins, pad enables, power-on state
	// Writes to status or unmapped words change nothing
	// Selection reset value zero picks the defaults everywhere
	// Configuration registers, written at the access edge with pready high
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_r <= PIOS_CTRL_RST;
			inclk_r <= PIOS_SEL_RST;
			inen_r <= PIOS_SEL_RST;
			inrst_r <= PIOS_SEL_RST;
			outclk_r <= PIOS_SEL_RST;
			outen_r <= PIOS_SEL_RST;
			outrst_r <= PIOS_SEL_RST;
		end else if (ce_i && wr_en) begin
			case (req.paddr[7:0])
				PIOS_CTRL_OFF: ctrl_r <= {1'b0, pwdata_i[5:0]};
				PIOS_INCLK_OFF: inclk_r <= pwdata_i[PIOS_SEL_W-1:0];
				PIOS_INEN_OFF: inen_r <= pwdata_i[PIOS_SEL_W-1:0];
				PIOS_INRST_OFF: inrst_r <= pwdata_i[PIOS_SEL_W-1:0];
				PIOS_OUTCLK_OFF: outclk_r <= pwdata_i[PIOS_SEL_W-1:0];
				PIOS_OUTEN_OFF: outen_r <= pwdata_i[PIOS_SEL_W-1:0];
				PIOS_OUTRST_OFF: outrst_r <= pwdata_i[PIOS_SEL_W-1:0];
				default: ;
			endcase
		end
	end

	// Full address compared, so aliases above the map answer an error
	// Read mux and decode, evaluated in the setup cycle
	always_comb begin
		rd_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		case (req.paddr)
			{24'h0, PIOS_CTRL_OFF}: rd_nxt = {25'h0, por_active_o, ctrl_r[5:0]};
			{24'h0, PIOS_INCLK_OFF}: rd_nxt = {25'h0, inclk_r};
			{24'h0, PIOS_INEN_OFF}: rd_nxt = {25'h0, inen_r};
			{24'h0, PIOS_INRST_OFF}: rd_nxt = {25'h0, inrst_r};
			{24'h0, PIOS_OUTCLK_OFF}: rd_nxt = {25'h0, outclk_r};
			{24'h0, PIOS_OUTEN_OFF}: rd_nxt = {25'h0, outen_r};
			{24'h0, PIOS_OUTRST_OFF}: rd_nxt = {25'h0, outrst_r};
			{24'h0, PIOS_STAT_OFF}: rd_nxt = {8'h00, por_state, 6'h00, pin_oe_o, pin_s_r};
			default: err_nxt = 1'b1;
		endcase
	end

	// Fixed latency: setup edge decodes, access edge answers
	// Read data is captured at setup and holds until the next setup
	// Hold ce_i high across a transfer: pready freezes high meanwhile,
	// and a write completing while frozen is lost
	// APB answer: no wait state, ready for exactly one cycle
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_o <= setup;
			pslverr_o <= setup && err_nxt;
			if (setup) begin
				prdata_o <= (req.pwrite || err_nxt) ? 32'h0000_0000 : rd_nxt;
			end
		end
	end
endmodule : pios_top
`default_nettype wire

// ---- src/pios_pkg.sv ----
package pios_pkg;
	// Register byte offsets
	localparam logic [7:0] PIOS_CTRL_OFF = 8'h00;
	localparam logic [7:0] PIOS_INCLK_OFF = 8'h04;
	localparam logic [7:0] PIOS_INEN_OFF = 8'h08;
	localparam logic [7:0] PIOS_INRST_OFF = 8'h0c;
	localparam logic [7:0] PIOS_OUTCLK_OFF = 8'h10;
	localparam logic [7:0] PIOS_OUTEN_OFF = 8'h14;
	localparam logic [7:0] PIOS_OUTRST_OFF = 8'h18;
	localparam logic [7:0] PIOS_STAT_OFF = 8'h1c;
	// Source selector encodings
	localparam logic [1:0] PIOS_SRC_DEF = 2'h0;
	localparam logic [1:0] PIOS_SRC_EXT = 2'h1;
	localparam logic [1:0] PIOS_SRC_PIN = 2'h2;
	// Input sync modes
	localparam logic [1:0] PIOS_IN_DOUBLE = 2'h0;
	localparam logic [1:0] PIOS_IN_SINGLE = 2'h1;
	localparam logic [1:0] PIOS_IN_TRANSP = 2'h2;
	// Source register fields: [1:0] src, [2] invert, [5:3] pin, [6] level mode
	localparam int PIOS_SRC_LSB = 0;
	localparam int PIOS_INV_BIT = 2;
	localparam int PIOS_IDX_LSB = 3;
	localparam int PIOS_MODE_BIT = 6;
	localparam int PIOS_SEL_W = 7;
	// Control register fields
	localparam int PIOS_INMODE_LSB = 0;
	localparam int PIOS_OSYNC_BIT = 2;
	localparam int PIOS_OESYNC_BIT = 3;
	localparam int PIOS_ORST_BIT = 4;
	localparam int PIOS_OERST_BIT = 5;
	localparam int PIOS_BOOT_BIT = 6;
	// Reset values
	localparam logic [PIOS_SEL_W-1:0] PIOS_SEL_RST = 7'h00;
	localparam logic [6:0] PIOS_CTRL_RST = 7'h00;
	// Power-on pin states
	localparam logic [1:0] PIOS_POR_DC = 2'h0;
	localparam logic [1:0] PIOS_POR_HIZ = 2'h1;
	localparam logic [1:0] PIOS_POR_UP = 2'h2;
	localparam logic [1:0] PIOS_POR_DN = 2'h3;

	typedef struct packed {
		logic level_mode;
		logic [2:0] pin;
		logic invert;
		logic [1:0] src;
	} pios_sel_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} pios_apb_req_t;
endpackage : pios_pkg

// ---- src/pios_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
// Turns a clock, enable and reset selection into an update strobe and clear
module pios_gate #(
	parameter int N = 8
) (
	input wire logic mclk_i, // System clock
	input wire logic sys_rst_i, // Async reset, high
	input wire logic ce_i, // Clock enable
	input wire pios_pkg::pios_sel_t clk_sel_i, // Clock source selection
	input wire pios_pkg::pios_sel_t en_sel_i, // Enable source selection
	input wire pios_pkg::pios_sel_t rst_sel_i, // Reset source selection
	input wire logic ext_clk_i, // External clock terminal
	input wire logic ext_en_i, // External enable terminal
	input wire logic ext_rst_i, // External reset terminal
	input wire logic [N-1:0] pins_i, // Synchronised pin levels
	output logic tick_o, // Update strobe
	output logic clr_o // Synchroniser clear
);
	import pios_pkg::*;
	logic clk_lvl, en_lvl, en_rise, armed, clk_edge;
	logic clk_prev_r, en_prev_r, armed_r;

	// Selected levels, inverted inside the block on request
	always_comb begin
		clk_lvl = clk_sel_i.invert ^ ((clk_sel_i.src == PIOS_SRC_PIN) ? pins_i[clk_sel_i.pin] :
			ext_clk_i);
		en_lvl = en_sel_i.invert ^ ((en_sel_i.src == PIOS_SRC_PIN) ? pins_i[en_sel_i.pin] :
			ext_en_i);
		clr_o = (rst_sel_i.src != PIOS_SRC_DEF) && (rst_sel_i.invert ^
			((rst_sel_i.src == PIOS_SRC_PIN) ? pins_i[rst_sel_i.pin] : ext_rst_i));
		// High-frequency clock means every system cycle is an edge
		clk_edge = (clk_sel_i.src == PIOS_SRC_DEF) || (clk_lvl && !clk_prev_r);
		en_rise = en_lvl && !en_prev_r;
		armed = armed_r || en_rise;
		if (en_sel_i.src == PIOS_SRC_DEF) begin
			tick_o = clk_edge;
		end else if (en_sel_i.level_mode) begin
			tick_o = clk_edge && en_lvl;
		end else begin
			tick_o = clk_edge && armed;
		end
	end

	// Edge history for clock and enable
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clk_prev_r <= 1'b0;
			en_prev_r <= 1'b0;
		end else if (ce_i) begin
			clk_prev_r <= clk_lvl;
			en_prev_r <= en_lvl;
		end
	end

	// One rise arms exactly one update; a rise in the same cycle as a clock edge is consumed by that edge
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			armed_r <= 1'b0;
		end else if (ce_i) begin
			if (en_rise) begin
				armed_r <= !clk_edge;
			end else if (clk_edge) begin
				armed_r <= 1'b0;
			end
		end
	end
endmodule : pios_gate
`default_nettype wire

// ---- dv/pios_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bus, pad and power-on checks seen from the top ports only
module pios_properties #(
	parameter int N = 8
) (
	input wire logic mclk_i, // Clock
	input wire logic sys_rst_i, // Reset
	input wire logic ce_i, // Enable
	input wire logic psel_i, // Select
	input wire logic penable_i, // Access
	input wire logic pwrite_i, // Write
	input wire logic [31:0] paddr_i, // Address
	input wire logic [31:0] pwdata_i, // Write data
	input wire logic [31:0] prdata_o, // Read data
	input wire logic pready_o, // Ready
	input wire logic pslverr_o, // Error
	input wire logic [N-1:0] pin_out_o, // Pad data
	input wire logic [N-1:0] pin_oe_o, // Pad enables
	input wire logic [N-1:0] fab_out_i, // Fabric data
	input wire logic [N-1:0] fab_oe_i, // Fabric enables
	input wire logic por_pull_up_o, // Pulled up
	input wire logic por_pull_dn_o, // Pulled down
	input wire logic por_active_o // Power-on state
);
	logic [5:0] sh_r;
	// Shadow of the control bits, so pass-through checks know the mode
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sh_r <= 6'h00;
		end else if (ce_i && psel_i && penable_i && pwrite_i && pready_o && paddr_i == 32'h0) begin
			sh_r <= pwdata_i[5:0];
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_setup;
		psel_i && !penable_i && ce_i;
	endsequence
	sequence s_bad;
		paddr_i > 32'h1c && paddr_i < 32'h100;
	endsequence
	sequence s_good;
		paddr_i <= 32'h1c && paddr_i[1:0] == 2'h0;
	endsequence
	a_ready_next: assert property (s_setup |=> pready_o) else $error("no ready after setup");
	a_ready_once: assert property (pready_o |=> !pready_o) else $error("ready held too long");
	a_ready_cause: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
		else $error("ready without setup");
	a_err_clean: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
		else $error("error without ready or with data");
	a_bad_addr: assert property (s_setup ##0 s_bad |=> pslverr_o) else $error("unmapped accepted");
	a_good_addr: assert property (s_setup ##0 s_good |=> pready_o && !pslverr_o)
		else $error("mapped refused");
	a_boot_hold: assert property (por_active_o && !(psel_i && penable_i && pwrite_i) |=> por_active_o)
		else $error("power-on state dropped without write");
	a_boot_wake: assert property ($fell(sys_rst_i) |-> por_active_o && pin_oe_o == '0)
		else $error("wrong state out of reset");
	a_pull_one: assert property (!(por_pull_up_o && por_pull_dn_o))
		else $error("both pulls on");
	a_out_pass: assert property (!sys_rst_i && !sh_r[2] && !sh_r[4] && ce_i
		|=> pin_out_o == $past(fab_out_i)) else $error("transparent data late");
	a_oe_pass: assert property (!sys_rst_i && !sh_r[3] && !sh_r[5] && ce_i
		|=> pin_oe_o == $past(fab_oe_i)) else $error("unsynced enable late");
endmodule : pios_properties
bind pios_top pios_properties #(.N(N)) u_props (.*);
`default_nettype wire

// ---- dv/pios_pads.sv ----
`timescale 1ns/1ps
`default_nettype none
// Off-chip source; it backs off wherever the chip drives, so no fights
module pios_pads #(
	parameter int N = 8
) (
	input wire logic [N-1:0] oe_i, // Chip drives
	input wire logic [N-1:0] out_i, // Chip value
	input wire logic [N-1:0] src_i, // Source value
	output logic [N-1:0] pad_o // Pad level
);
	// Resolved level seen by the input synchronisers
	assign pad_o = (oe_i & out_i) | (~oe_i & src_i);
endmodule : pios_pads
`default_nettype wire

// ---- dv/pios_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module pios_top_test;
	import pios_pkg::*;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
	logic pwrite_i = 1'b0, pready_o, pslverr_o, por_pull_up_o, por_pull_dn_o, por_active_o;
	logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o;
	logic [7:0] fab_out_i = 8'h00, fab_oe_i = 8'h00, src = 8'h00;
	logic [7:0] pin_in_i, pin_out_o, pin_oe_o, fab_in_o;
	logic in_clk_i = 1'b0, in_en_i = 1'b0, in_rst_i = 1'b0;
	logic out_clk_i = 1'b0, out_en_i = 1'b0, out_rst_i = 1'b0;
	int err_total = 0, total_checks = 0;
	// Pins 3 and 5 ask for pull-up, the rest do not care
	pios_top #(.N(8), .POR_CFG(16'h0880)) u_dut (.*);
	pios_pads #(.N(8)) u_pads (.oe_i(pin_oe_o), .out_i(pin_out_o), .src_i(src), .pad_o(pin_in_i));
	// 100 MHz clock
	always #5 mclk_i = ~mclk_i;
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : cyc
	// One APB transfer; only the watchdog bounds the wait for ready
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		`CHK(e, 1'b0);
	endtask : wr
	task automatic t_reset;
		logic [31:0] q;
		logic e;
		cyc(2);
		`CHK(por_active_o, 1'b1);
		`CHK(por_pull_up_o, 1'b1);
		`CHK(por_pull_dn_o, 1'b0);
		apb(1'b0, PIOS_STAT_OFF, 32'h0, q, e);
		`CHK(q[23:22], PIOS_POR_UP);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, i * 4, 32'h0, q, e);
			`CHK(q, (i == 0) ? 32'h0000_0040 : 32'h0000_0000);
		end
		$display("t_reset done");
	endtask : t_reset
	task automatic t_in;
		src <= 8'ha5;
		cyc(8);
		`CHK(fab_in_o, 8'ha5);
		wr(PIOS_CTRL_OFF, 32'h2);
		src <= 8'h77;
		cyc(8);
		`CHK(fab_in_o, 8'h77);
		wr(PIOS_CTRL_OFF, 32'h1);
		wr(PIOS_INEN_OFF, 32'h01);
		src <= 8'h5a;
		cyc(8);
		`CHK(fab_in_o, 8'h77);
		in_en_i <= 1'b1;
		cyc(8);
		`CHK(fab_in_o, 8'h5a);
		src <= 8'h3c;
		cyc(8);
		`CHK(fab_in_o, 8'h5a);
		wr(PIOS_INEN_OFF, 32'h41);
		cyc(8);
		`CHK(fab_in_o, 8'h3c);
		in_en_i <= 1'b0;
		src <= 8'hc3;
		cyc(8);
		`CHK(fab_in_o, 8'h3c);
		wr(PIOS_INEN_OFF, 32'h0);
		cyc(8);
		`CHK(fab_in_o, 8'hc3);
		$display("t_in done");
	endtask : t_in
	task automatic t_rst;
		wr(PIOS_INRST_OFF, 32'h01);
		in_rst_i <= 1'b1;
		cyc(6);
		`CHK(fab_in_o, 8'h00);
		wr(PIOS_INRST_OFF, 32'h05);
		cyc(6);
		`CHK(fab_in_o, 8'hc3);
		in_rst_i <= 1'b0;
		cyc(6);
		`CHK(fab_in_o, 8'h00);
		wr(PIOS_INCLK_OFF, 32'h01);
		wr(PIOS_INRST_OFF, 32'h0);
		src <= 8'h11;
		cyc(6);
		`CHK(fab_in_o, 8'h00);
		in_clk_i <= 1'b1;
		cyc(6);
		`CHK(fab_in_o, 8'h11);
		wr(PIOS_INCLK_OFF, 32'h3a);
		src <= 8'h22;
		cyc(6);
		`CHK(fab_in_o, 8'h11);
		src <= 8'ha2;
		cyc(6);
		`CHK(fab_in_o, 8'ha2);
		wr(PIOS_INCLK_OFF, 32'h0);
		$display("t_rst done");
	endtask : t_rst
	task automatic t_out;
		fab_oe_i <= 8'hff;
		fab_out_i <= 8'h96;
		cyc(4);
		`CHK(pin_out_o, 8'h96);
		wr(PIOS_CTRL_OFF, 32'h04);
		wr(PIOS_OUTEN_OFF, 32'h01);
		fab_out_i <= 8'h69;
		cyc(6);
		`CHK(pin_out_o, 8'h96);
		out_en_i <= 1'b1;
		cyc(6);
		`CHK(pin_out_o, 8'h69);
		fab_out_i <= 8'h0f;
		cyc(6);
		`CHK(pin_out_o, 8'h69);
		wr(PIOS_OUTCLK_OFF, 32'h01);
		wr(PIOS_OUTEN_OFF, 32'h41);
		fab_out_i <= 8'hf0;
		cyc(6);
		`CHK(pin_out_o, 8'h69);
		wr(PIOS_OUTCLK_OFF, 32'h0);
		cyc(6);
		`CHK(pin_out_o, 8'hf0);
		wr(PIOS_CTRL_OFF, 32'h3c);
		wr(PIOS_OUTRST_OFF, 32'h01);
		out_rst_i <= 1'b1;
		cyc(6);
		`CHK(pin_out_o, 8'h00);
		`CHK(pin_oe_o, 8'h00);
		out_rst_i <= 1'b0;
		cyc(6);
		`CHK(pin_out_o, 8'hf0);
		`CHK(pin_oe_o, 8'hff);
		$display("t_out done");
	endtask : t_out
	task automatic t_bus;
		logic [31:0] q;
		logic e;
		apb(1'b0, 32'h40, 32'h0, q, e);
		`CHK(e, 1'b1);
		`CHK(q, 32'h0);
		wr(PIOS_CTRL_OFF, 32'h40);
		cyc(2);
		`CHK(por_active_o, 1'b0);
		$display("t_bus done");
	endtask : t_bus
	// Clock enable freeze, then a reset in mid-run re-arms the power-on state
	task automatic t_ce;
		logic [31:0] q;
		logic e;
		fab_out_i <= 8'h5a;
		cyc(2);
		ce_i <= 1'b0;
		fab_out_i <= 8'h33;
		cyc(4);
		`CHK(pin_out_o, 8'h5a);
		ce_i <= 1'b1;
		cyc(2);
		`CHK(pin_out_o, 8'h33);
		sys_rst_i <= 1'b1;
		cyc(2);
		sys_rst_i <= 1'b0;
		cyc(2);
		`CHK(por_active_o, 1'b1);
		`CHK(por_pull_up_o, 1'b1);
		apb(1'b0, PIOS_CTRL_OFF, 32'h0, q, e);
		`CHK(q, 32'h0000_0040);
		$display("t_ce done");
	endtask : t_ce
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	// Main sequence after a 20-cycle reset
	initial begin
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_in();
		t_rst();
		t_out();
		t_bus();
		t_ce();
		end_sim();
	end
	// Tests need about 280 cycles; 5000 leaves ample margin
	initial begin
		repeat (5000) @(posedge mclk_i);
		err_total++;
		end_sim();
	end
endmodule : pios_top_test
`default_nettype wire
